// ===== src/tcmvc_pkg.sv
// Package for the timer channel mode decoder and value coherency block.
// Assumes a byte-wide register port and a counter supplied from outside.
package tcmvc_pkg;

   // Byte register addresses on the plain register port
   localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
   localparam logic [1:0] ADDR_VALUE_HIGH     = 2'h1;
   localparam logic [1:0] ADDR_VALUE_LOW      = 2'h2;

   // Field positions in channel_status_control
   localparam int SC_FLAG_BIT   = 7;
   localparam int SC_IE_BIT     = 6;
   localparam int SC_MODE_B_BIT = 5;
   localparam int SC_MODE_A_BIT = 4;
   localparam int SC_ELS_B_BIT  = 3;
   localparam int SC_ELS_A_BIT  = 2;

   // Reset values
   localparam logic [15:0] VALUE_RESET = 16'h0000;
   localparam logic [7:0]  BYTE_ZERO   = 8'h00;

   // Edge/level select encodings
   localparam logic [1:0] ELS_OFF     = 2'h0;
   localparam logic [1:0] ELS_RISE    = 2'h1;
   localparam logic [1:0] ELS_FALL    = 2'h2;
   localparam logic [1:0] ELS_BOTH    = 2'h3;

   // Clock source select meaning counter stopped
   localparam logic [1:0] CLKS_STOPPED = 2'h0;

   // Free-running terminal count and the count just below it
   localparam logic [15:0] FREE_TOP      = 16'hFFFF;
   localparam logic [15:0] FREE_TOP_LESS = 16'hFFFE;
   localparam logic [15:0] ONE_16        = 16'h0001;

   // Channel operating modes, one-hot
   typedef enum logic [4:0] {
      CH_RELEASED = 5'h01,
      CH_CAPTURE  = 5'h02,
      CH_COMPARE  = 5'h04,
      CH_EDGE_ALIGNED_PWM     = 5'h08,
      CH_CENTER_ALIGNED_PWM     = 5'h10
   } tcmvc_mode_type;

endpackage : tcmvc_pkg

// ===== src/tcmvc_channel.sv
// Single timer channel: mode decode, pin control, capture, compare and PWM
// output, and byte-coherent access to the 16-bit channel value.
// Assumes the counter, modulo and clock select live in the timer core and
// arrive as inputs synchronous to i_sys_clk.
//
// Summary of operation
// R1 - Mode A picks capture or compare
// R2 - Software keeps pin stable before capture
// R3 - Select bits zero release the pin
// R4 - Capture on rising, falling or both edges
// R5 - Compare toggles, clears or sets pin
// R6 - Mode B gives edge-aligned PWM polarity
// R7 - Center-aligned bit forces center-aligned PWM
// R8 - Value holds capture or compare, resets zero
// R9 - Byte read latches both bytes until other
// R10 - Control write unlatches read buffer
// R11 - Value writes ignored during capture
// R12 - Debug freezes read latch, reads live
// R13 - Both bytes written transfer as one
// R14 - Stopped counter loads on second byte
// R15 - Compare loads on next counter increment
// R16 - PWM loads at modulo minus one step
// R17 - Control write clears partial write sequence
// R18 - Debug writes bypass buffer, latch frozen
// R19 - Pending sequence survives debug direct writes
// R20 - Active edge copies counter into value
// R21 - Flag on event, not at 0%/100%
// R22 - Clock select zero means counter stopped
// R23 - Unlisted combos map to nearest mode
`timescale 1ns/1ps

module tcmvc_channel (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rstn,
   // Register port
   input  wire logic [1:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   // Timer core context
   input  wire logic        i_center_aligned_select,
   input  wire logic [1:0]  i_clock_source,
   input  wire logic [15:0] i_counter,
   input  wire logic        i_count_tick,
   input  wire logic        i_count_down,
   input  wire logic [15:0] i_modulo,
   input  wire logic        i_debug_halt_mode,
   // Channel pin
   input  wire logic        i_pin,
   output logic             o_pin,
   output logic             o_pin_oe,
   output logic             o_pin_claim,
   // Status
   output logic             o_channel_event_flag,
   output logic             o_channel_int_enable,
   output logic [15:0]      o_channel_value
);

   // Mode decode shared by pin control and the value path
   function automatic tcmvc_pkg::tcmvc_mode_type decode_mode(
      input logic       cas,
      input logic       mb,
      input logic       ma,
      input logic [1:0] els
   );
      tcmvc_pkg::tcmvc_mode_type m;
      m = tcmvc_pkg::CH_RELEASED;
      if (els == tcmvc_pkg::ELS_OFF) begin
         m = tcmvc_pkg::CH_RELEASED;                     // R3 R23
      end else if (cas) begin
         m = tcmvc_pkg::CH_CENTER_ALIGNED_PWM;                         // R7
      end else if (mb) begin
         m = tcmvc_pkg::CH_EDGE_ALIGNED_PWM;                         // R6
      end else if (ma) begin
         m = tcmvc_pkg::CH_COMPARE;                      // R1
      end else begin
         m = tcmvc_pkg::CH_CAPTURE;                      // R1
      end
      return m;
   endfunction

   // Control fields
   logic        flag_q;
   logic        ie_q;
   logic        mode_b_q;
   logic        mode_a_q;
   logic [1:0]  els_q;
   logic        clear_armed_q;
   // Value and coherency state
   logic [15:0] value_q;
   logic [15:0] rbuf_q;
   logic        rlatched_q;
   logic        rfirst_high_q;
   logic [7:0]  wbuf_high_q;
   logic [7:0]  wbuf_low_q;
   logic        wgot_high_q;
   logic        wgot_low_q;
   logic        wpending_q;
   // Pin and output state
   logic        pin_prev_q;
   logic        out_q;
   logic [7:0]  rdata_q;

   tcmvc_pkg::tcmvc_mode_type mode;
   logic        sc_wr;
   logic        sc_rd;
   logic        vh_wr;
   logic        vl_wr;
   logic        vh_rd;
   logic        vl_rd;
   logic        debug;
   logic        stopped;
   logic        is_pwm;
   logic        rise;
   logic        fall;
   logic        capture_hit;
   logic [15:0] top;
   logic [15:0] top_less;
   logic        match;
   logic        period_start;
   logic        pwm_edge_duty;
   logic        compare_flag;
   logic        flag_event;
   logic        seq_done;
   logic [15:0] seq_value;
   logic        load_now;
   logic        load_pending;

   // Access decode
   assign sc_wr   = i_wr && (i_addr == tcmvc_pkg::ADDR_STATUS_CONTROL);
   assign sc_rd   = i_rd && (i_addr == tcmvc_pkg::ADDR_STATUS_CONTROL);
   assign vh_wr   = i_wr && (i_addr == tcmvc_pkg::ADDR_VALUE_HIGH);
   assign vl_wr   = i_wr && (i_addr == tcmvc_pkg::ADDR_VALUE_LOW);
   assign vh_rd   = i_rd && (i_addr == tcmvc_pkg::ADDR_VALUE_HIGH);
   assign vl_rd   = i_rd && (i_addr == tcmvc_pkg::ADDR_VALUE_LOW);
   assign debug   = i_debug_halt_mode;
   assign stopped = (i_clock_source == tcmvc_pkg::CLKS_STOPPED);   // R22

   // Current channel mode
   assign mode   = decode_mode(i_center_aligned_select, mode_b_q, mode_a_q, els_q);
   assign is_pwm = (mode == tcmvc_pkg::CH_EDGE_ALIGNED_PWM) || (mode == tcmvc_pkg::CH_CENTER_ALIGNED_PWM);

   // Pin edge detection for capture
   assign rise        = i_pin && !pin_prev_q;
   assign fall        = !i_pin && pin_prev_q;
   always_comb begin
      capture_hit = 1'b0;
      if (mode == tcmvc_pkg::CH_CAPTURE) begin
         unique case (els_q)
            tcmvc_pkg::ELS_RISE: capture_hit = rise;                // R4
            tcmvc_pkg::ELS_FALL: capture_hit = fall;                // R4
            tcmvc_pkg::ELS_BOTH: capture_hit = rise || fall;        // R4
            default:             capture_hit = 1'b0;
         endcase
      end
   end

   // Terminal count: modulo, or free-running when modulo is zero
   assign top      = (i_modulo == 16'h0000) ? tcmvc_pkg::FREE_TOP : i_modulo;
   assign top_less = (i_modulo == 16'h0000) ? tcmvc_pkg::FREE_TOP_LESS
                                            : 16'(i_modulo - tcmvc_pkg::ONE_16);

   // Compare match taken as the counter leaves the matching count
   assign match        = i_count_tick && !stopped && (i_counter == value_q);
   assign period_start = i_count_tick && !stopped && (i_counter == top) && !i_count_down;
   // Duty strictly between 0% and 100%
   assign pwm_edge_duty = (value_q != 16'h0000) && (value_q <= top);
   assign compare_flag  = match && (!is_pwm || pwm_edge_duty);            // R21
   assign flag_event    = capture_hit ||
                          (compare_flag && (mode != tcmvc_pkg::CH_CAPTURE) &&
                           (mode != tcmvc_pkg::CH_RELEASED));             // R21

   // Pin ownership: timer drives only in output modes
   assign o_pin_claim = (mode != tcmvc_pkg::CH_RELEASED);                 // R3
   assign o_pin_oe    = (mode == tcmvc_pkg::CH_COMPARE) || is_pwm;        // R3
   assign o_pin       = out_q;
   assign o_rdata     = rdata_q;
   assign o_channel_event_flag = flag_q;
   assign o_channel_int_enable = ie_q;
   assign o_channel_value      = value_q;

   // Previous pin sample for edge detection
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pin_prev_q <= 1'b0;
      end else begin
         pin_prev_q <= i_pin;
      end
   end

   // Control bits of channel_status_control
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ie_q     <= 1'b0;
         mode_b_q <= 1'b0;
         mode_a_q <= 1'b0;
         els_q    <= tcmvc_pkg::ELS_OFF;
      end else if (sc_wr) begin
         ie_q     <= i_wdata[tcmvc_pkg::SC_IE_BIT];
         mode_b_q <= i_wdata[tcmvc_pkg::SC_MODE_B_BIT];
         mode_a_q <= i_wdata[tcmvc_pkg::SC_MODE_A_BIT];
         els_q    <= {i_wdata[tcmvc_pkg::SC_ELS_B_BIT], i_wdata[tcmvc_pkg::SC_ELS_A_BIT]};
      end
   end

   // Event flag: set wins, clear needs a read while set then write of 0
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         flag_q        <= 1'b0;
         clear_armed_q <= 1'b0;
      end else if (flag_event) begin
         flag_q        <= 1'b1;                                           // R21
         clear_armed_q <= 1'b0;
      end else if (sc_wr && clear_armed_q && !i_wdata[tcmvc_pkg::SC_FLAG_BIT]) begin
         flag_q        <= 1'b0;
         clear_armed_q <= 1'b0;
      end else if (sc_rd && flag_q) begin
         clear_armed_q <= 1'b1;
      end
   end

   // Capture read coherency latch
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rbuf_q        <= tcmvc_pkg::VALUE_RESET;
         rlatched_q    <= 1'b0;
         rfirst_high_q <= 1'b0;
      end else if (sc_wr) begin
         rlatched_q <= 1'b0;                                              // R10
      end else if (!debug && (mode == tcmvc_pkg::CH_CAPTURE) && (vh_rd || vl_rd)) begin
         if (!rlatched_q) begin
            rbuf_q        <= value_q;                                     // R9
            rlatched_q    <= 1'b1;
            rfirst_high_q <= vh_rd;
         end else if (vh_rd != rfirst_high_q) begin
            rlatched_q <= 1'b0;                                           // R9
         end
      end
   end

   // Read data, valid only in the cycle after the read strobe
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rdata_q <= tcmvc_pkg::BYTE_ZERO;
      end else if (sc_rd) begin
         rdata_q <= {flag_q, ie_q, mode_b_q, mode_a_q, els_q, 2'h0};
      end else if (vh_rd) begin
         // Buffered copy only while latched outside debug
         rdata_q <= (rlatched_q && !debug && (mode == tcmvc_pkg::CH_CAPTURE))
                    ? rbuf_q[15:8] : value_q[15:8];                       // R12
      end else if (vl_rd) begin
         rdata_q <= (rlatched_q && !debug && (mode == tcmvc_pkg::CH_CAPTURE))
                    ? rbuf_q[7:0] : value_q[7:0];                         // R12
      end else begin
         rdata_q <= tcmvc_pkg::BYTE_ZERO;
      end
   end

   // Write sequence completes on the second of the two bytes
   assign seq_done  = !debug && (mode != tcmvc_pkg::CH_CAPTURE) && !sc_wr &&
                      ((vh_wr && wgot_low_q) || (vl_wr && wgot_high_q));  // R13
   assign seq_value = {vh_wr ? i_wdata : wbuf_high_q, vl_wr ? i_wdata : wbuf_low_q};

   // Deferred load timing depends on clock and mode
   always_comb begin
      load_pending = 1'b0;
      if (wpending_q) begin
         if (stopped) begin
            load_pending = 1'b1;                                          // R14
         end else if (mode == tcmvc_pkg::CH_COMPARE) begin
            load_pending = i_count_tick;                                  // R15
         end else if (is_pwm) begin
            load_pending = i_count_tick && !i_count_down &&
                           (i_counter == top_less);                       // R16
         end else begin
            load_pending = 1'b0;
         end
      end
   end
   assign load_now = seq_done && stopped;                                 // R14

   // Write buffer and its latches, frozen in debug
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wbuf_high_q <= tcmvc_pkg::BYTE_ZERO;
         wbuf_low_q  <= tcmvc_pkg::BYTE_ZERO;
         wgot_high_q <= 1'b0;
         wgot_low_q  <= 1'b0;
         wpending_q  <= 1'b0;
      end else if (sc_wr) begin
         wgot_high_q <= 1'b0;                                             // R17
         wgot_low_q  <= 1'b0;                                             // R17
         if (load_pending) begin
            wpending_q <= 1'b0;
         end
      end else if (seq_done) begin
         wbuf_high_q <= seq_value[15:8];                                  // R13
         wbuf_low_q  <= seq_value[7:0];
         wgot_high_q <= 1'b0;
         wgot_low_q  <= 1'b0;
         wpending_q  <= !stopped;                                         // R15 R16
      end else begin
         if (!debug && (mode != tcmvc_pkg::CH_CAPTURE)) begin             // R11 R18
            if (vh_wr) begin
               wbuf_high_q <= i_wdata;
               wgot_high_q <= 1'b1;
            end
            if (vl_wr) begin
               wbuf_low_q <= i_wdata;
               wgot_low_q <= 1'b1;
            end
         end
         if (load_pending) begin
            wpending_q <= 1'b0;
         end
      end
   end

   // Channel value register
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         value_q <= tcmvc_pkg::VALUE_RESET;                               // R8
      end else if (capture_hit) begin
         value_q <= i_counter;                                            // R20
      end else if (load_now) begin
         value_q <= seq_value;                                            // R14
      end else if (load_pending) begin
         value_q <= {wbuf_high_q, wbuf_low_q};                            // R19
      end else if (debug && (mode != tcmvc_pkg::CH_CAPTURE)) begin
         // Direct byte writes while halted
         if (vh_wr) begin
            value_q[15:8] <= i_wdata;                                     // R18 R19
         end
         if (vl_wr) begin
            value_q[7:0] <= i_wdata;                                      // R18
         end
      end
   end

   // Output level for compare and PWM
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         out_q <= 1'b0;
      end else begin
         unique case (mode)
            tcmvc_pkg::CH_COMPARE: begin
               if (match) begin
                  unique case (els_q)
                     tcmvc_pkg::ELS_RISE: out_q <= !out_q;                // R5
                     tcmvc_pkg::ELS_FALL: out_q <= 1'b0;                  // R5
                     tcmvc_pkg::ELS_BOTH: out_q <= 1'b1;                  // R5
                     default:             out_q <= out_q;
                  endcase
               end
            end
            tcmvc_pkg::CH_EDGE_ALIGNED_PWM: begin
               // High-true for 10, low-true for X1
               if (match && (value_q != 16'h0000)) begin
                  out_q <= els_q[0];                                      // R6
               end else if (period_start) begin
                  out_q <= (value_q == 16'h0000) ? els_q[0] : !els_q[0];  // R6
               end
            end
            tcmvc_pkg::CH_CENTER_ALIGNED_PWM: begin
               if (match && !i_count_down) begin
                  out_q <= els_q[0];                                      // R7
               end else if (match && i_count_down) begin
                  out_q <= !els_q[0];                                     // R7
               end
            end
            tcmvc_pkg::CH_RELEASED,
            tcmvc_pkg::CH_CAPTURE: begin
               out_q <= out_q;
            end
         endcase
      end
   end

endmodule // tcmvc_channel

// ===== verification/tcmvc_assertions.sv
// Checker for the timer channel: mode decode, capture, compare, debug writes.
// Assumes it is bound to tcmvc_channel and sees only its ports.
`timescale 1ns/1ps

module tcmvc_checker (
   input wire logic        i_sys_clk,
   input wire logic        i_rstn,
   input wire logic [1:0]  i_addr,
   input wire logic [7:0]  i_wdata,
   input wire logic        i_wr,
   input wire logic        i_center_aligned_select,
   input wire logic [1:0]  i_clock_source,
   input wire logic [15:0] i_counter,
   input wire logic        i_count_tick,
   input wire logic        i_debug_halt_mode,
   input wire logic        i_pin,
   input wire logic        o_pin,
   input wire logic        o_pin_oe,
   input wire logic        o_pin_claim,
   input wire logic [15:0] o_channel_value
);
   logic [5:2] ctl_q;
   logic       cap;
   logic       cmp;

   // Mirror of the mode and select bits last written
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctl_q <= 4'h0;
      end else if (i_wr && i_addr == tcmvc_pkg::ADDR_STATUS_CONTROL) begin
         ctl_q <= i_wdata[5:2];
      end
   end

   // Decoded capture and compare modes
   assign cap = !i_center_aligned_select && ctl_q[5:4] == 2'h0 && ctl_q[3:2] != 2'h0;
   assign cmp = !i_center_aligned_select && ctl_q[5:4] == 2'h1 && ctl_q[3:2] != 2'h0;

   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);

   // Pin ownership per mode
   pin_release_a: assert property (ctl_q[3:2] == 2'h0 |-> !o_pin_claim && !o_pin_oe)
      else $error("pin not released with select bits zero");
   capture_input_a: assert property (cap |-> o_pin_claim && !o_pin_oe)
      else $error("capture mode drives the pin");
   compare_drive_a: assert property (cmp |-> o_pin_oe)
      else $error("compare mode does not drive the pin");
   center_force_a: assert property (i_center_aligned_select && ctl_q[3:2] != 2'h0 |-> o_pin_oe)
      else $error("center-aligned mode does not drive the pin");
   // Value after reset release
   reset_value_a: assert property ($rose(i_rstn) |-> o_channel_value == tcmvc_pkg::VALUE_RESET)
      else $error("channel value not zero after reset");
   // Capture behaviour
   capture_copy_a: assert property (cap && ctl_q[3:2] == tcmvc_pkg::ELS_BOTH
      && i_pin != $past(i_pin) |=> o_channel_value == $past(i_counter))
      else $error("edge did not capture the counter");
   rise_only_a: assert property (cap && ctl_q[3:2] == tcmvc_pkg::ELS_RISE && $fell(i_pin)
      |=> $stable(o_channel_value))
      else $error("falling edge captured in rising mode");
   capture_nowrite_a: assert property (cap && i_wr
      && i_addr != tcmvc_pkg::ADDR_STATUS_CONTROL
      && $stable(i_pin) |=> $stable(o_channel_value))
      else $error("value write accepted in capture mode");
   // Debug direct write and compare toggle
   debug_direct_a: assert property (cmp && i_debug_halt_mode && i_wr
      && i_addr == tcmvc_pkg::ADDR_VALUE_LOW |=> o_channel_value[7:0] == $past(i_wdata))
      else $error("debug write did not reach the register");
   toggle_match_a: assert property (cmp && ctl_q[3:2] == tcmvc_pkg::ELS_RISE && i_count_tick
      && i_clock_source != tcmvc_pkg::CLKS_STOPPED
      && i_counter == o_channel_value |=> o_pin != $past(o_pin))
      else $error("compare match did not toggle the pin");

   // Main scenarios reached
   cover property (cap && i_pin != $past(i_pin));
   cover property (cmp && i_count_tick && i_counter == o_channel_value);
   cover property (i_debug_halt_mode && i_wr);
endmodule // tcmvc_checker

bind tcmvc_channel tcmvc_checker u_chk (.i_sys_clk, .i_rstn, .i_addr, .i_wdata, .i_wr,
   .i_center_aligned_select, .i_counter, .i_count_tick, .i_debug_halt_mode, .i_pin,
   .o_pin, .o_pin_oe, .o_pin_claim, .o_channel_value, .i_clock_source);

// ===== verification/tcmvc_pin_model.sv
// Far side of the channel pin: an external driver that the timer can override.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/1ps

module tcmvc_pin_model (
   input  wire logic i_sys_clk,
   input  wire logic i_pin_out,
   input  wire logic i_pin_oe,
   output logic      o_line
);
   logic lvl_q = 1'b0;

   // Timer wins while it drives, else the external level shows
   assign o_line = i_pin_oe ? i_pin_out : lvl_q;

   // Move the external level, then hold it two clocks
   task automatic drive(input logic v);
      lvl_q <= v;
      repeat (2) @(posedge i_sys_clk);
   endtask

   // Follow the line so a switch to capture sees no edge
   task automatic settle();
      lvl_q <= o_line;
      repeat (2) @(posedge i_sys_clk);
   endtask
endmodule // tcmvc_pin_model

// ===== verification/tb_timer_channel_mode_and_value_coherency.sv
// Self-checking bench for the timer channel over its byte register port.
// Assumes the checker is bound in and the pin model stands on the pin.
`timescale 1ns/1ps

module tb_timer_channel_mode_and_value_coherency;
   logic        i_sys_clk = 1'b0;
   logic        i_rstn = 1'b0;
   logic [1:0]  i_addr = 2'h0;
   logic [7:0]  i_wdata = 8'h00;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic        i_center_aligned_select = 1'b0;
   logic [1:0]  i_clock_source = 2'h0;
   logic [15:0] i_counter = 16'h0000;
   logic        i_count_tick = 1'b0;
   logic        i_debug_halt_mode = 1'b0;
   logic        i_count_down = 1'b0;
   logic [15:0] i_modulo = 16'h0000;
   logic        o_channel_int_enable;
   logic        i_pin;
   logic [7:0]  o_rdata;
   logic        o_pin, o_pin_oe, o_pin_claim, o_channel_event_flag;
   logic [15:0] o_channel_value;
   int          fails = 0;
   int          checks = 0;
   logic [7:0]  rd_q[$];
   logic        rd_pend = 1'b0;
   logic [15:0] v, w, c;
   logic        prev;
   // Mode table: center bit, control byte, pin enable, pin claim
   logic [10:0] mt[6] = '{11'h000, 11'h4C0, 11'h011, 11'h053, 11'h0A3, 11'h423};

   always #10 i_sys_clk = ~i_sys_clk;

   tcmvc_channel DUT (.i_sys_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_center_aligned_select, .i_clock_source, .i_counter, .i_count_tick,
      .i_count_down, .i_modulo, .i_debug_halt_mode, .i_pin, .o_pin,
      .o_pin_oe, .o_pin_claim, .o_channel_event_flag, .o_channel_int_enable,
      .o_channel_value);
   tcmvc_pin_model pin (.i_sys_clk, .i_pin_out(o_pin), .i_pin_oe(o_pin_oe), .o_line(i_pin));

   task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask

   // One-cycle write, then one idle edge
   task automatic wr(input logic [1:0] a, input logic [7:0] dat);
      i_addr <= a;
      i_wdata <= dat;
      i_wr <= 1'b1;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
      @(posedge i_sys_clk);
   endtask

   // One-cycle read; the answer is noted for the monitor
   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      rd_q.push_back(exp);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      @(posedge i_sys_clk);
   endtask

   // One counter step at the given count
   task automatic tick(input logic [15:0] cnt);
      i_counter <= cnt;
      i_count_tick <= 1'b1;
      @(posedge i_sys_clk);
      i_count_tick <= 1'b0;
      @(posedge i_sys_clk);
   endtask

   task automatic cv(input logic [15:0] exp);
      #1;
      check("value", o_channel_value, exp);
   endtask

   task automatic complete_run();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Read data stands only in the cycle after the strobe
   always @(negedge i_sys_clk) begin
      if (rd_pend) begin
         check("rdata", {8'h00, o_rdata}, {8'h00, rd_q.pop_front()});
      end
      rd_pend = i_rd;
   end

   // Tests need about 140 clocks; far beyond that is a hang
   initial begin
      #200000;
      fails++;
      complete_run();
   end

   initial begin
      void'($urandom(32'hF20FFAFB));
      repeat (16) @(posedge i_sys_clk);
      i_rstn <= 1'b1;
      @(posedge i_sys_clk);
      rd(2'h0, 8'h00);
      rd(2'h1, 8'h00);
      rd(2'h3, 8'h00);
      cv(16'h0000);
      $display("test reset done");
      // Pin enable and claim for every mode row
      for (int i = 0; i < 6; i++) begin
         i_center_aligned_select <= mt[i][10];
         wr(2'h0, mt[i][9:2]);
         #1;
         check("pin_oe", {15'h0, o_pin_oe}, {15'h0, mt[i][1]});
         check("pin_claim", {15'h0, o_pin_claim}, {15'h0, mt[i][0]});
      end
      $display("test mode decode done");
      // Stopped counter: pair loads on the second byte, control write drops a half
      i_center_aligned_select <= 1'b0;
      wr(2'h0, 8'h14);
      rd(2'h0, 8'h14);
      v = 16'($urandom);
      wr(2'h2, v[7:0]);
      cv(16'h0000);
      wr(2'h1, v[15:8]);
      cv(v);
      w = 16'($urandom);
      wr(2'h1, w[15:8]);
      wr(2'h0, 8'h14);
      wr(2'h2, w[7:0]);
      cv(v);
      wr(2'h1, 8'h5A);
      cv({8'h5A, w[7:0]});
      // Debug write goes direct, pending half survives
      wr(2'h1, w[15:8]);
      i_debug_halt_mode <= 1'b1;
      wr(2'h2, 8'hC3);
      cv(16'h5AC3);
      i_debug_halt_mode <= 1'b0;
      wr(2'h2, w[7:0]);
      cv(w);
      $display("test stopped and debug writes done");
      // Running counter: compare loads on next step, then each match action
      i_clock_source <= 2'h1;
      v = 16'($urandom);
      wr(2'h1, v[15:8]);
      wr(2'h2, v[7:0]);
      cv(w);
      tick(~v);
      cv(v);
      for (int e = 1; e < 4; e++) begin
         wr(2'h0, 8'h10 | 8'(e << 2));
         #1;
         prev = o_pin;
         tick(v);
         #1;
         check("pin", {15'h0, o_pin}, {15'h0, (e == 1) ? ~prev : (e == 3)});
         check("flag", {15'h0, o_channel_event_flag}, 16'h0001);
      end
      // Flag clears by a read while set, then a write of 0
      rd(2'h0, 8'h9C);
      wr(2'h0, 8'h5C);
      #1;
      check("flag", {15'h0, o_channel_event_flag}, 16'h0000);
      check("int_enable", {15'h0, o_channel_int_enable}, 16'h0001);
      $display("test compare done");
      // Edge PWM loads only on the step to the top
      wr(2'h0, 8'h28);
      w = 16'($urandom);
      wr(2'h1, w[15:8]);
      wr(2'h2, w[7:0]);
      tick(16'h1234);
      cv(v);
      tick(16'hFFFE);
      cv(w);
      // With a modulo the load waits for modulo minus one
      i_modulo <= 16'h1235;
      wr(2'h1, v[15:8]);
      wr(2'h2, v[7:0]);
      tick(16'hFFFE);
      cv(w);
      tick(16'h1234);
      cv(v);
      // Center-aligned output on up and down matches
      i_center_aligned_select <= 1'b1;
      wr(2'h0, 8'h08);
      tick(v);
      #1;
      check("pin", {15'h0, o_pin}, 16'h0000);
      i_count_down <= 1'b1;
      tick(v);
      #1;
      check("pin", {15'h0, o_pin}, 16'h0001);
      i_center_aligned_select <= 1'b0;
      i_count_down <= 1'b0;
      $display("test pwm load done");
      // Capture on both edges, read latch, ignored writes, unlatch, debug reads
      i_clock_source <= 2'h0;
      pin.settle();
      wr(2'h0, 8'h0C);
      c = 16'($urandom);
      i_counter <= c;
      pin.drive(~i_pin);
      cv(c);
      rd(2'h1, c[15:8]);
      i_counter <= ~c;
      pin.drive(~i_pin);
      cv(~c);
      rd(2'h2, c[7:0]);
      wr(2'h1, 8'hA5);
      cv(~c);
      rd(2'h1, ~c[15:8]);
      i_counter <= c ^ 16'h0F0F;
      pin.drive(~i_pin);
      wr(2'h0, 8'h0C);
      rd(2'h2, c[7:0] ^ 8'h0F);
      i_debug_halt_mode <= 1'b1;
      i_counter <= 16'h8421;
      pin.drive(~i_pin);
      rd(2'h1, 8'h84);
      i_debug_halt_mode <= 1'b0;
      rd(2'h1, c[15:8] ^ 8'h0F);
      // Rising-only select ignores the falling edge
      wr(2'h0, 8'h04);
      pin.drive(1'b0);
      i_counter <= 16'h1357;
      pin.drive(1'b1);
      i_counter <= 16'h2468;
      pin.drive(1'b0);
      cv(16'h1357);
      $display("test capture done");
      complete_run();
   end
endmodule // tb_timer_channel_mode_and_value_coherency
